// >>> design/prmr_regbank.sv
// Purpose: paged register bank with strap address and soft resets
// Assumes: one access port shared by local target and remote channel
// Notes: a port holds its request until it is granted
// Functional notes
// - both local and remote ports reach everything
// - rx range read-select, write-enable broadcast
// - rx debug range shares rx paging
// - csi range paged by bit 4/bit 0
// - other listed ranges are single shared copies
// - address bits 7:1 show current target address
// - override 0: field read-only, strap value
// - override 1: field writable, used as address
// - reload bit restarts rom load, self-clears
// - full reset clears logic and configuration
// - partial reset keeps configuration registers
// - init done set when rom load completes
`timescale 1ns/1ps
module prmr_regbank (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic [6:0] strap_addr_in,
	input wire logic loc_req_in,
	input wire logic loc_wr_in,
	input wire logic [7:0] loc_addr_in,
	input wire logic [7:0] loc_wdata_in,
	output logic loc_ack_out,
	output logic [7:0] loc_rdata_out,
	input wire logic rem_req_in,
	input wire logic rem_wr_in,
	input wire logic [7:0] rem_addr_in,
	input wire logic [7:0] rem_wdata_in,
	output logic rem_ack_out,
	output logic [7:0] rem_rdata_out,
	output logic [6:0] target_addr_out,
	output logic logic_rst_out
);
	// shared register storage; rx paged ranges get per-port copies, csi range a single copy
	logic [7:0] shared_q [256];
	logic [7:0] rx_q [prmr_pkg::RX_PORTS][64];
	logic [7:0] rxdbg_q [prmr_pkg::RX_PORTS][16];
	logic [7:0] csi_q [8];
	logic [6:0] strap_q;
	logic strap_taken_q;
	logic override_q;
	logic [6:0] prog_addr_q;
	logic [2:0] sc_q;
	logic [3:0] pulse_cnt_q;
	logic full_pend_q;
	logic [7:0] loc_rd_q, rem_rd_q;
	logic loc_ack_q, rem_ack_q;
	logic init_done;
	logic cfg_rst;

	// arbitration: local port wins, remote waits one access
	wire logic sel_loc = loc_req_in && !loc_ack_q;
	wire logic sel_rem = rem_req_in && !rem_ack_q && !sel_loc;
	wire logic acc = sel_loc || sel_rem;
	wire logic wr = sel_loc ? loc_wr_in : rem_wr_in;
	wire logic [7:0] a = sel_loc ? loc_addr_in : rem_addr_in;
	wire logic [7:0] wd = sel_loc ? loc_wdata_in : rem_wdata_in;
	wire logic we = acc && wr && !logic_rst_out;
	wire logic [7:0] rx_sel = shared_q[prmr_pkg::ADDR_RX_SEL];
	wire logic [7:0] csi_sel = shared_q[prmr_pkg::ADDR_CSI_SEL];
	wire logic [1:0] rx_rd_port = rx_sel[5:4];

	function automatic logic in_range(input logic [7:0] x,
		input logic [7:0] lo, input logic [7:0] hi);
		return (x >= lo) && (x <= hi);
	endfunction

	// reserved ranges answer zero and take no writes
	function automatic logic is_reserved(input logic [7:0] x);
		return in_range(x, 8'h3B, 8'h3F) || in_range(x, 8'h80, 8'h8F) ||
			in_range(x, 8'hA0, 8'hAF) || in_range(x, 8'hC0, 8'hCF) ||
			in_range(x, 8'hE0, 8'hEF) || in_range(x, 8'hF6, 8'hF7) ||
			in_range(x, 8'hFC, 8'hFF);
	endfunction

	// the page select sits inside the rx range but must never be paged,
	// or a page change would only reach the copy it is read from
	wire logic hit_rx = in_range(a, prmr_pkg::RX_LO, prmr_pkg::RX_HI) &&
		(a != prmr_pkg::ADDR_RX_SEL);
	wire logic hit_dbg = in_range(a, prmr_pkg::RXDBG_LO,
		prmr_pkg::RXDBG_HI);
	wire logic hit_csi = in_range(a, prmr_pkg::CSI_LO, prmr_pkg::CSI_HI);
	wire logic hit_res = is_reserved(a);
	wire logic [5:0] rx_idx = 6'(a - prmr_pkg::RX_LO);
	wire logic [3:0] dbg_idx = a[3:0];
	wire logic [2:0] csi_idx = 3'(a - prmr_pkg::CSI_LO);
	wire logic [6:0] cur_addr = override_q ? prog_addr_q : strap_q;

	// read mux; csi page 1 does not exist here and reads zero
	logic [7:0] rd;
	always_comb begin
		rd = shared_q[a];
		if (hit_res) begin
			rd = 8'h00;
		end else if (a == prmr_pkg::ADDR_TARGET) begin
			rd = {cur_addr, override_q};
		end else if (a == prmr_pkg::ADDR_RESET) begin
			rd = {5'h00, sc_q};
		end else if (a == prmr_pkg::ADDR_STATUS) begin
			rd = 8'h00;
			rd[prmr_pkg::BIT_INIT_DONE] = init_done;
		end else if (hit_rx) begin
			rd = rx_q[rx_rd_port][rx_idx];
		end else if (hit_dbg) begin
			rd = rxdbg_q[rx_rd_port][dbg_idx];
		end else if (hit_csi) begin
			rd = csi_sel[prmr_pkg::BIT_CSI_RD] ? 8'h00 : csi_q[csi_idx];
		end
	end

	// configuration is cleared by the pin reset or a full reset only
	assign cfg_rst = rst_in || full_pend_q;

	always_ff @(posedge sys_clk_in) begin
		if (cfg_rst) begin
			for (int i = 0; i < 256; i++) begin
				shared_q[i] <= 8'h00;
			end
			shared_q[prmr_pkg::ADDR_RX_SEL] <= prmr_pkg::RX_SEL_RESET;
			shared_q[prmr_pkg::ADDR_CSI_SEL] <= prmr_pkg::CSI_SEL_RESET;
			override_q <= 1'b0;
			prog_addr_q <= 7'h00;
		end else if (we && !hit_res && !hit_rx && !hit_dbg && !hit_csi) begin
			if (a == prmr_pkg::ADDR_TARGET) begin
				override_q <= wd[prmr_pkg::BIT_OVERRIDE];
				if (override_q) begin
					prog_addr_q <= wd[7:1];
				end else begin
					prog_addr_q <= strap_q;
				end
			end else if (a != prmr_pkg::ADDR_RESET &&
				a != prmr_pkg::ADDR_STATUS) begin
				shared_q[a] <= wd;
			end
		end
	end

	// paged copies; every enabled page takes the write together
	always_ff @(posedge sys_clk_in) begin
		if (cfg_rst) begin
			for (int p = 0; p < prmr_pkg::RX_PORTS; p++) begin
				for (int i = 0; i < 64; i++) begin
					rx_q[p][i] <= 8'h00;
				end
				for (int i = 0; i < 16; i++) begin
					rxdbg_q[p][i] <= 8'h00;
				end
			end
			for (int i = 0; i < 8; i++) begin
				csi_q[i] <= 8'h00;
			end
		end else if (we) begin
			for (int p = 0; p < prmr_pkg::RX_PORTS; p++) begin
				if (rx_sel[p] && hit_rx) begin
					rx_q[p][rx_idx] <= wd;
				end
				if (rx_sel[p] && hit_dbg) begin
					rxdbg_q[p][dbg_idx] <= wd;
				end
			end
			if (csi_sel[prmr_pkg::BIT_CSI_WR] && hit_csi) begin
				csi_q[csi_idx] <= wd;
			end
		end
	end

	// strap capture happens once, after the pin reset releases
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			strap_q <= 7'h00;
			strap_taken_q <= 1'b0;
		end else if (!strap_taken_q) begin
			strap_q <= strap_addr_in;
			strap_taken_q <= 1'b1;
		end
	end

	// self-clearing control bits; they live one cycle only
	wire logic wr_reset = we && (a == prmr_pkg::ADDR_RESET);
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			sc_q <= 3'h0;
		end else if (wr_reset) begin
			sc_q <= wd[2:0]; // writing 0 does nothing
		end else begin
			sc_q <= 3'h0;
		end
	end

	// internal logic reset pulse; full reset also clears configuration
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			pulse_cnt_q <= 4'h0;
			full_pend_q <= 1'b0;
		end else if (sc_q[prmr_pkg::BIT_FULL] ||
			sc_q[prmr_pkg::BIT_PARTIAL]) begin
			pulse_cnt_q <= prmr_pkg::PULSE_CYCLES;
			full_pend_q <= sc_q[prmr_pkg::BIT_FULL];
		end else if (pulse_cnt_q != 4'h0) begin
			pulse_cnt_q <= pulse_cnt_q - 4'h1;
			full_pend_q <= 1'b0;
		end else begin
			full_pend_q <= 1'b0;
		end
	end
	assign logic_rst_out = (pulse_cnt_q != 4'h0);

	// a reload or a full reset reruns the rom load; partial keeps it
	prmr_loader u_loader (
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.start_in(sc_q[prmr_pkg::BIT_RELOAD] || full_pend_q),
		.done_out(init_done)
	);

	// answers registered one cycle after the grant
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			loc_ack_q <= 1'b0;
			rem_ack_q <= 1'b0;
			loc_rd_q <= 8'h00;
			rem_rd_q <= 8'h00;
		end else begin
			loc_ack_q <= sel_loc;
			rem_ack_q <= sel_rem;
			if (sel_loc) begin
				loc_rd_q <= rd;
			end
			if (sel_rem) begin
				rem_rd_q <= rd;
			end
		end
	end
	assign loc_ack_out = loc_ack_q;
	assign rem_ack_out = rem_ack_q;
	assign loc_rdata_out = loc_rd_q;
	assign rem_rdata_out = rem_rd_q;
	assign target_addr_out = cur_addr;

	// checkers; pulse and loader lengths follow the package counts
	chk_sc_clears: assert property (@(posedge sys_clk_in)
		disable iff (rst_in) wr_reset |=> ##1 (sc_q == 3'h0))
		else $error("self-clearing bit stuck");
	chk_reload_start: assert property (@(posedge sys_clk_in)
		disable iff (rst_in) (wr_reset && wd[2]) |=> ##2 !init_done)
		else $error("reload did not restart load");
	chk_full_clears: assert property (@(posedge sys_clk_in)
		disable iff (rst_in) full_pend_q |=> (override_q == 1'b0))
		else $error("full reset kept config");
	// a write granted in the launch cycle may still land, not later ones
	chk_partial_keeps: assert property (@(posedge sys_clk_in)
		disable iff (rst_in) (logic_rst_out && !full_pend_q)
		|=> $stable(override_q))
		else $error("partial reset changed config");
	chk_strap_addr: assert property (@(posedge sys_clk_in)
		disable iff (rst_in)
		(we && a == prmr_pkg::ADDR_TARGET && !override_q)
		|=> target_addr_out == $past(target_addr_out))
		else $error("strap address overwritten");
	chk_addr_readback: assert property (@(posedge sys_clk_in)
		disable iff (rst_in) (sel_loc && a == prmr_pkg::ADDR_TARGET)
		|=> loc_rdata_out[7:1] == $past(cur_addr))
		else $error("address readback wrong");
	chk_reserved_zero: assert property (@(posedge sys_clk_in)
		disable iff (rst_in) (sel_loc && hit_res) |=> loc_rdata_out == 8'h00)
		else $error("reserved read not zero");
	chk_logic_rst_len: assert property (@(posedge sys_clk_in)
		disable iff (rst_in) (wr_reset && wd[0]) |=> ##1 logic_rst_out [*4])
		else $error("logic reset pulse short");
	chk_sel_shared: assert property (@(posedge sys_clk_in)
		disable iff (rst_in) (we && a == prmr_pkg::ADDR_RX_SEL)
		|=> rx_sel == $past(wd))
		else $error("page select not shared");
	chk_rx_read_page: assert property (@(posedge sys_clk_in)
		disable iff (rst_in) (sel_loc && !wr && hit_rx)
		|=> loc_rdata_out == $past(rx_q[rx_rd_port][rx_idx]))
		else $error("rx read took wrong page");
	chk_dbg_bcast: assert property (@(posedge sys_clk_in)
		disable iff (rst_in) (we && hit_dbg && rx_sel[3])
		|=> rxdbg_q[3][$past(dbg_idx)] == $past(wd))
		else $error("debug broadcast missed port 3");
	chk_csi_wr_gate: assert property (@(posedge sys_clk_in)
		disable iff (rst_in)
		(we && hit_csi && !csi_sel[prmr_pkg::BIT_CSI_WR])
		|=> csi_q[$past(csi_idx)] == $past(csi_q[csi_idx]))
		else $error("disabled csi page took a write");
	cov_broadcast: cover property (@(posedge sys_clk_in)
		we && hit_rx && rx_sel[3:0] == 4'hF);
	cov_remote: cover property (@(posedge sys_clk_in) sel_rem && wr);
	cov_reload: cover property (@(posedge sys_clk_in)
		sc_q[2] ##[1:40] init_done);
	cov_partial: cover property (@(posedge sys_clk_in)
		sc_q[prmr_pkg::BIT_PARTIAL] ##1 logic_rst_out);
	cov_csi_page1: cover property (@(posedge sys_clk_in)
		sel_loc && hit_csi && !wr && csi_sel[prmr_pkg::BIT_CSI_RD]);
endmodule

// >>> design/prmr_pkg.sv
// Purpose: constants for the paged register map with soft reset
// Assumes: 8-bit register address space, 8-bit data
// Notes: offsets, fields, reset values and cycle counts live here
package prmr_pkg;
	localparam logic [7:0] ADDR_TARGET = 8'h00;
	localparam logic [7:0] ADDR_RESET = 8'h01;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_CSI_SEL = 8'h32;
	localparam logic [7:0] ADDR_RX_SEL = 8'h4C;
	localparam logic [7:0] CSI_LO = 8'h33;
	localparam logic [7:0] CSI_HI = 8'h3A;
	localparam logic [7:0] RX_LO = 8'h46;
	localparam logic [7:0] RX_HI = 8'h7F;
	localparam logic [7:0] RXDBG_LO = 8'hD0;
	localparam logic [7:0] RXDBG_HI = 8'hDF;
	localparam int RX_PORTS = 4;
	localparam int BIT_OVERRIDE = 0;
	localparam int BIT_PARTIAL = 0;
	localparam int BIT_FULL = 1;
	localparam int BIT_RELOAD = 2;
	localparam int BIT_INIT_DONE = 6;
	localparam int BIT_CSI_RD = 4;
	localparam int BIT_CSI_WR = 0;
	localparam logic [7:0] RESET_VAL = 8'h00;
	localparam logic [7:0] RX_SEL_RESET = 8'h00;
	localparam logic [7:0] CSI_SEL_RESET = 8'h01;
	// length of the internal logic reset pulse and of a rom load
	localparam logic [3:0] PULSE_CYCLES = 4'h4;
	localparam logic [7:0] LOAD_CYCLES = 8'h10;
	typedef enum logic [1:0] {
		PRMR_IDLE = 2'b00,
		PRMR_LOAD = 2'b01,
		PRMR_DONE = 2'b11
	} prmr_load_t;
endpackage

// >>> design/prmr_loader.sv
// Purpose: models the rom configuration load sequence
// Assumes: start is a one-cycle pulse
// Notes: done stays high once a load completes until the next start
`timescale 1ns/1ps
module prmr_loader (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic start_in,
	output logic done_out
);
	prmr_pkg::prmr_load_t state_q, state_d;
	logic [7:0] cnt_q, cnt_d;
	wire logic count_end = (cnt_q == prmr_pkg::LOAD_CYCLES);

	// next state: reset also restarts the load, as at power-up
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		unique case (state_q)
			prmr_pkg::PRMR_IDLE: begin
				state_d = prmr_pkg::PRMR_LOAD;
				cnt_d = 8'h00;
			end
			prmr_pkg::PRMR_LOAD: begin
				cnt_d = cnt_q + 8'h01;
				if (count_end) begin
					state_d = prmr_pkg::PRMR_DONE;
				end
			end
			prmr_pkg::PRMR_DONE: begin
				cnt_d = 8'h00;
			end
			default: begin
				state_d = prmr_pkg::PRMR_IDLE;
			end
		endcase
		if (start_in) begin
			state_d = prmr_pkg::PRMR_LOAD;
			cnt_d = 8'h00;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			state_q <= prmr_pkg::PRMR_IDLE;
			cnt_q <= 8'h00;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
		end
	end

	assign done_out = (state_q == prmr_pkg::PRMR_DONE);

	chk_done_after_load: assert property (@(posedge sys_clk_in)
		disable iff (rst_in) (start_in ##1 !start_in [*8]) |-> !done_out)
		else $error("done rose too early after a reload");
endmodule

// >>> tb/prmr_host.sv
// Purpose: access port host model, local target or remote channel
// Assumes: one access at a time, request held until ack is sampled
// Notes: released address and data lines show inverted values
`timescale 1ns/1ps
module prmr_host (
	input wire logic sys_clk_in,
	input wire logic ack_in,
	input wire logic [7:0] rdata_in,
	output logic req_out,
	output logic wr_out,
	output logic [7:0] addr_out,
	output logic [7:0] wdata_out
);
	// accesses whose ack never came; the bench counts them as mismatches
	int n_to;
	// lines are driven from time zero
	initial begin
		n_to = 0;
		req_out = 1'b0;
		wr_out = 1'b0;
		addr_out = 8'h00;
		wdata_out = 8'h00;
	end
	// request stays up through the edge that samples ack high
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [7:0] d, output logic [7:0] rd);
		int n;
		n = 0;
		@(negedge sys_clk_in);
		req_out = 1'b1;
		wr_out = w;
		addr_out = a;
		wdata_out = d;
		do begin
			@(negedge sys_clk_in);
			n++;
		end while (ack_in !== 1'b1 && n < 50);
		if (ack_in !== 1'b1) n_to++;
		@(posedge sys_clk_in);
		rd = rdata_in;
		@(negedge sys_clk_in);
		// inverted so a stale value is never mistaken for a live one
		req_out = 1'b0;
		wr_out = ~w;
		addr_out = ~a;
		wdata_out = ~d;
	endtask
endmodule

// >>> tb/tb_top.sv
// Purpose: self-checking bench for the paged register bank
// Assumes: reads queue their expected value, a monitor compares
// Notes: strap pins are tied to one arbitrary address
`timescale 1ns/1ps
module tb_top;
	localparam logic [6:0] STRAP = 7'h2D;
	localparam logic [7:0] PA [2] = '{prmr_pkg::RX_LO, prmr_pkg::RXDBG_HI};
	localparam logic [7:0] SEL = prmr_pkg::ADDR_RX_SEL;
	logic sys_clk_in, rst_in, lrd, rrd, lrst;
	logic l_req, l_wr, l_ack, r_req, r_wr, r_ack;
	logic [7:0] l_a, l_d, l_q, r_a, r_d, r_q, lfsr, v, r;
	logic [6:0] tgt;
	logic [7:0] expq[$];
	int n_errors, cmp_count, cyc, k, hi_n, last_len;

	prmr_regbank prmr_regbank_i (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
		.strap_addr_in(STRAP), .loc_req_in(l_req), .loc_wr_in(l_wr),
		.loc_addr_in(l_a), .loc_wdata_in(l_d), .loc_ack_out(l_ack),
		.loc_rdata_out(l_q), .rem_req_in(r_req), .rem_wr_in(r_wr),
		.rem_addr_in(r_a), .rem_wdata_in(r_d), .rem_ack_out(r_ack),
		.rem_rdata_out(r_q), .target_addr_out(tgt), .logic_rst_out(lrst));
	prmr_host loc_i (.sys_clk_in(sys_clk_in), .ack_in(l_ack),
		.rdata_in(l_q), .req_out(l_req), .wr_out(l_wr), .addr_out(l_a),
		.wdata_out(l_d));
	prmr_host rem_i (.sys_clk_in(sys_clk_in), .ack_in(r_ack),
		.rdata_in(r_q), .req_out(r_req), .wr_out(r_wr), .addr_out(r_a),
		.wdata_out(r_d));

	function automatic logic [7:0] nxt(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic check(input logic [7:0] g, input logic [7:0] e);
		cmp_count++;
		if (g !== e) begin
			n_errors++;
			$display("Error %0t got %h exp %h", $time, g, e);
		end
	endtask
	// one access; a checked read queues its expected value d
	task automatic acc(input bit rm, input logic w, input logic [7:0] ad,
		input logic [7:0] d, input bit c);
		if (!w && c) expq.push_back(d);
		lrd = !rm && !w && c;
		rrd = rm && !w && c;
		if (rm) rem_i.xfer(w, ad, d, r);
		else loc_i.xfer(w, ad, d, r);
		lrd = 1'b0;
		rrd = 1'b0;
	endtask
	task automatic tally_and_finish;
		n_errors += loc_i.n_to + rem_i.n_to;
		$display("compares %0d errors %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	initial begin
		sys_clk_in = 1'b0;
		forever #10 sys_clk_in = ~sys_clk_in;
	end
	// monitor: each checked read answer against the oldest note; also time-out
	always @(posedge sys_clk_in) begin
		cyc++;
		if ((l_ack === 1'b1 && lrd) || (r_ack === 1'b1 && rrd))
			check(l_ack === 1'b1 ? l_q : r_q,
				expq.size() ? expq.pop_front() : 8'hXX);
		if (lrst === 1'b1) hi_n++;
		else if (hi_n != 0) begin
			last_len = hi_n;
			hi_n = 0;
		end
		if (cyc == 6000) begin
			n_errors++;
			tally_and_finish();
		end
	end

	initial begin
		rst_in = 1'b1;
		lrd = 1'b0;
		rrd = 1'b0;
		lfsr = 8'h1F;
		repeat (16) @(negedge sys_clk_in);
		rst_in = 1'b0;
		repeat (2) @(negedge sys_clk_in);
		acc(0, 0, 8'h00, {STRAP, 1'b0}, 1);
		check({1'b0, tgt}, {1'b0, STRAP});
		acc(1, 1, 8'h00, 8'hA4, 0);
		acc(1, 0, 8'h00, {STRAP, 1'b0}, 1);
		acc(0, 1, 8'h00, 8'h01, 0);
		acc(1, 1, 8'h00, 8'hA5, 0);
		acc(0, 0, 8'h00, 8'hA5, 1);
		check({1'b0, tgt}, 8'h52);
		$display("target address test done");
		// broadcast, then port 0 alone, then read every page
		foreach (PA[i]) begin
			lfsr = nxt(lfsr);
			v = lfsr;
			lfsr = nxt(lfsr);
			acc(0, 1, SEL, 8'h0F, 0);
			acc(1, 1, PA[i], v, 0);
			acc(0, 1, SEL, 8'h01, 0);
			acc(0, 1, PA[i], lfsr, 0);
			for (int p = 0; p < prmr_pkg::RX_PORTS; p++) begin
				acc(0, 1, SEL, {2'b00, 2'(p), 4'h0}, 0);
				acc(p[0], 0, PA[i], p == 0 ? lfsr : v, 1);
			end
		end
		$display("rx paging test done");
		lfsr = nxt(lfsr);
		acc(1, 1, prmr_pkg::CSI_HI, lfsr, 0);
		acc(0, 1, prmr_pkg::ADDR_CSI_SEL, 8'h00, 0);
		acc(0, 1, prmr_pkg::CSI_HI, ~lfsr, 0);
		acc(0, 0, prmr_pkg::CSI_HI, lfsr, 1);
		acc(0, 1, prmr_pkg::ADDR_CSI_SEL, 8'h11, 0);
		acc(0, 0, prmr_pkg::CSI_HI, 8'h00, 1);
		acc(0, 1, prmr_pkg::ADDR_CSI_SEL, prmr_pkg::CSI_SEL_RESET, 0);
		$display("csi paging test done");
		// shared copy ignores page selects; reserved space is inert
		acc(0, 1, SEL, 8'h21, 0);
		acc(1, 1, 8'h41, 8'h5A, 0);
		acc(0, 1, SEL, 8'h32, 0);
		acc(0, 0, 8'h41, 8'h5A, 1);
		acc(0, 1, 8'h85, 8'hFF, 0);
		acc(1, 0, 8'h85, 8'h00, 1);
		acc(0, 1, 8'hFC, 8'hFF, 0);
		acc(0, 0, 8'h41, 8'h5A, 1);
		$display("shared and reserved test done");
		// rom reload, then poll init done
		acc(0, 1, prmr_pkg::ADDR_RESET, 8'h04, 0);
		acc(0, 0, prmr_pkg::ADDR_RESET, 8'h00, 1);
		acc(1, 0, prmr_pkg::ADDR_STATUS, 8'h00, 0);
		check({7'h00, r[6]}, 8'h00);
		k = 0;
		while (r[6] !== 1'b1 && k < 40) begin
			acc(1, 0, prmr_pkg::ADDR_STATUS, 8'h00, 0);
			k++;
		end
		check({7'h00, r[6]}, 8'h01);
		$display("reload test done");
		// partial reset keeps configuration, full reset clears it
		last_len = 0;
		acc(0, 1, prmr_pkg::ADDR_RESET, 8'h01, 0);
		repeat (30) @(negedge sys_clk_in);
		check(8'(last_len), 8'h04);
		acc(0, 0, 8'h41, 8'h5A, 1);
		acc(1, 0, SEL, 8'h32, 1);
		last_len = 0;
		acc(1, 1, prmr_pkg::ADDR_RESET, 8'h02, 0);
		repeat (30) @(negedge sys_clk_in);
		check(8'(last_len), 8'h04);
		acc(0, 0, 8'h41, prmr_pkg::RESET_VAL, 1);
		acc(0, 0, SEL, prmr_pkg::RX_SEL_RESET, 1);
		acc(1, 0, 8'h00, {STRAP, 1'b0}, 1);
		acc(0, 0, prmr_pkg::ADDR_RESET, 8'h00, 1);
		$display("soft reset test done");
		tally_and_finish();
	end
endmodule
